// file: hdl/mcs_params.svh
// Constants for the measurement calibration scaler
`ifndef MCS_PARAMS_SVH
`define MCS_PARAMS_SVH

// ==========================================================
// Channels
`define MCS_NUM_CH          10
`define MCS_NUM_CELLS       5
`define MCS_CH_CELL1        0
`define MCS_CH_STACK        5
`define MCS_CH_FAST         6
`define MCS_CH_CURR         7
`define MCS_CH_THERM        8
`define MCS_CH_DIE          9
`define MCS_TAG_W           4

// ==========================================================
// Calibration register indices (word index, byte address = 4 x index)
`define MCS_NUM_CFG         13
`define MCS_CFG_CELL_GAIN   0
`define MCS_CFG_DELTA_BASE  1
`define MCS_CFG_STACK_GAIN  5
`define MCS_CFG_CURR_GAIN   6
`define MCS_CFG_CURR_OFF    7
`define MCS_CFG_FAST_GAIN   8
`define MCS_CFG_FAST_OFF    9
`define MCS_CFG_THERM_OFF   10
`define MCS_CFG_DIE_GAIN    11
`define MCS_CFG_DIE_OFF     12
`define MCS_WORD_RES_BASE   16
`define MCS_WORD_STATUS     26
`define MCS_CFG_RESET       16'h0000
`define MCS_DELTA_MSB       7
`define MCS_ADR_W           8

// ==========================================================
// Arithmetic
`define MCS_STACK_HI_MSB    31
`define MCS_STACK_HI_LSB    16
`define MCS_GAIN_SHIFT      16
`define MCS_SAT_MAX         16'h7FFF
`define MCS_SAT_MIN         16'h8000
`define MCS_ZERO_OFF        16'h0000

`endif

// file: hdl/mcs_pkg.sv
// Types shared by the calibration scaler modules
`include "mcs_params.svh"

package mcs_pkg;

    typedef enum logic [1:0] {
        MCS_ST_IDLE  = 2'b00,
        MCS_ST_ISSUE = 2'b01,
        MCS_ST_WAIT  = 2'b11
    } mcs_state_t;

    typedef struct packed {
        mcs_state_t                                st;
        logic [`MCS_NUM_CFG-1:0][15:0]             cfg;
        logic [`MCS_NUM_CH-1:0][15:0]              raw;
        logic [`MCS_NUM_CH-1:0]                    pend;
        logic [`MCS_TAG_W-1:0]                     tag;
        logic [`MCS_NUM_CH-1:0][15:0]              res;
        logic [`MCS_NUM_CH-1:0]                    res_vld;
        logic                                      ack;
        logic [31:0]                               dat;
    } mcs_top_state_t;

    typedef struct packed {
        logic                                      vld;
        logic [`MCS_TAG_W-1:0]                     tag;
        logic [15:0]                               val;
    } mcs_arith_state_t;

endpackage

// file: hdl/mcs_arith_if.sv
// Request and answer between the sequencer and the arithmetic unit
`timescale 1ns/1ps
`include "mcs_params.svh"

interface mcs_arith_if;
    logic                         req_valid;
    logic [`MCS_TAG_W-1:0]        req_tag;
    logic signed [16:0]           req_a;
    logic signed [15:0]           req_off;
    logic signed [17:0]           req_gain;
    logic                         req_byp;
    logic                         rsp_valid;
    logic [`MCS_TAG_W-1:0]        rsp_tag;
    logic signed [15:0]           rsp_value;

    modport seq  (output req_valid, req_tag, req_a, req_off, req_gain, req_byp,
                  input  rsp_valid, rsp_tag, rsp_value);
    modport unit (input  req_valid, req_tag, req_a, req_off, req_gain, req_byp,
                  output rsp_valid, rsp_tag, rsp_value);
endinterface

// file: hdl/mcs_arith.sv
// Offset, gain and saturation unit, one cycle latency
`timescale 1ns/1ps
`include "mcs_params.svh"

module mcs_arith (
    input  wire logic    sys_clk,   // System clock
    input  wire logic    rst,       // Synchronous reset
    mcs_arith_if.unit    ai         // Request and answer
);

    mcs_pkg::mcs_arith_state_t s_q;
    mcs_pkg::mcs_arith_state_t s_d;
    logic signed [17:0]        diff;
    logic signed [35:0]        prod;
    logic signed [35:0]        scaled;

    // ==========================================================
    // Datapath
    always_comb begin
        s_d    = s_q;
        diff   = $signed({ai.req_a[16], ai.req_a}) - $signed({{2{ai.req_off[15]}}, ai.req_off});
        prod   = diff * ai.req_gain;
        // Both arms signed, so the shift stays arithmetic
        scaled = ai.req_byp ? 36'(diff)
                            : (prod >>> `MCS_GAIN_SHIFT);
        s_d.vld = ai.req_valid;
        s_d.tag = ai.req_tag;
        if (ai.req_valid) begin
            if (scaled > $signed({20'h00000, `MCS_SAT_MAX})) begin
                s_d.val = `MCS_SAT_MAX;
            end else if (scaled < $signed({20'hFFFFF, `MCS_SAT_MIN})) begin
                s_d.val = `MCS_SAT_MIN;
            end else begin
                s_d.val = scaled[15:0];
            end
        end
    end

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end

    assign ai.rsp_valid = s_q.vld;
    assign ai.rsp_tag   = s_q.tag;
    assign ai.rsp_value = s_q.val;

    // ==========================================================
    // Checks
    logic signed [63:0] chk_ref;
    assign chk_ref = ai.req_byp ? (64'(ai.req_a) - 64'(ai.req_off))
                                : (((64'(ai.req_a) - 64'(ai.req_off)) * 64'(ai.req_gain)) >>> `MCS_GAIN_SHIFT);

    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (rst);

    a_arith_latency: assert property (ai.req_valid |=> ai.rsp_valid && ai.rsp_tag == $past(ai.req_tag))
        else $error("arith answer missing or wrong tag");
    a_scale_exact: assert property (ai.req_valid && chk_ref <= 64'sd32767 && chk_ref >= -64'sd32768
        |=> ai.rsp_value == $past(chk_ref[15:0]))
        else $error("scaled value wrong");
    a_sat_high: assert property (ai.req_valid && chk_ref > 64'sd32767 |=> ai.rsp_value == `MCS_SAT_MAX)
        else $error("no positive saturation");
    a_sat_low: assert property (ai.req_valid && chk_ref < -64'sd32768 |=> ai.rsp_value == `MCS_SAT_MIN)
        else $error("no negative saturation");
    a_idle_quiet: assert property (!ai.req_valid |=> !ai.rsp_valid)
        else $error("spurious arith answer");

    c_saturate: cover property (ai.req_valid && chk_ref > 64'sd32767);
    c_bypass: cover property (ai.req_valid && ai.req_byp);

endmodule

// file: hdl/mcs_top.sv
// Calibration scaler: registers, channel sequencing and result reporting
`timescale 1ns/1ps
`include "mcs_params.svh"

// Behaviour
// - Cell one scaled by its unsigned gain
// - Cells two to five: gain plus signed delta
// - Cells two to five scaled by derived gain
// - Stack uses upper raw half times gain
// - Second filter: subtract offset, then gain
// - First filter: own offset, then own gain
// - Thermistor: offset subtracted, no gain
// - Die temperature: offset then gain
module mcs_top (
    input  wire logic                              sys_clk,             // System clock, 250 MHz
    input  wire logic                              rst,                 // Synchronous reset, active high
    input  wire logic                              wb_cyc,              // Wishbone cycle
    input  wire logic                              wb_stb,              // Wishbone strobe
    input  wire logic                              wb_we,               // Wishbone write enable
    input  wire logic [`MCS_ADR_W-1:0]             wb_adr,              // Wishbone byte address
    input  wire logic [3:0]                        wb_sel,              // Wishbone byte selects
    input  wire logic [31:0]                       wb_dat_w,            // Wishbone write data
    output logic      [31:0]                       wb_dat_r,            // Wishbone read data
    output logic                                   wb_ack,              // Wishbone acknowledge
    input  wire logic [`MCS_NUM_CELLS-1:0][15:0]   raw_cell,            // Raw cell results, signed
    input  wire logic [31:0]                       raw_stack,           // Raw stack result
    input  wire logic [15:0]                       raw_coulomb_first,   // Raw first filter result
    input  wire logic [15:0]                       raw_coulomb_second,  // Raw second filter result
    input  wire logic [15:0]                       raw_thermistor,      // Raw thermistor_input result
    input  wire logic [15:0]                       raw_die_temp,        // Raw die temperature result
    input  wire logic [`MCS_NUM_CH-1:0]            raw_valid,           // New raw result per channel
    output logic      [`MCS_NUM_CH-1:0][15:0]      rep_value,           // Calibrated results
    output logic      [`MCS_NUM_CH-1:0]            rep_valid            // Result updated pulse
);

    mcs_pkg::mcs_top_state_t           s_q;
    mcs_pkg::mcs_top_state_t           s_d;
    mcs_arith_if                       ai ();
    logic [`MCS_NUM_CH-1:0][15:0]      raw_in;
    logic signed [16:0]                op_a    [`MCS_NUM_CH];
    logic signed [15:0]                op_off  [`MCS_NUM_CH];
    logic signed [17:0]                op_gain [`MCS_NUM_CH];
    logic                              op_byp  [`MCS_NUM_CH];
    logic [5:0]                        word;

    // ==========================================================
    // Raw input gathering
    always_comb begin
        for (int i = 0; i < `MCS_NUM_CELLS; i++) begin
            raw_in[i] = raw_cell[i];
        end
        raw_in[`MCS_CH_STACK] = raw_stack[`MCS_STACK_HI_MSB:`MCS_STACK_HI_LSB];
        raw_in[`MCS_CH_FAST]  = raw_coulomb_first;
        raw_in[`MCS_CH_CURR]  = raw_coulomb_second;
        raw_in[`MCS_CH_THERM] = raw_thermistor;
        raw_in[`MCS_CH_DIE]   = raw_die_temp;
    end

    // ==========================================================
    // Per-channel operands
    for (genvar i = 0; i < `MCS_NUM_CH; i++) begin : g_op
        if (i == `MCS_CH_CELL1) begin : g_c1
            assign op_a[i]    = {s_q.raw[i][15], s_q.raw[i]};
            assign op_off[i]  = `MCS_ZERO_OFF;
            assign op_gain[i] = {2'b00, s_q.cfg[`MCS_CFG_CELL_GAIN]};
            assign op_byp[i]  = 1'b0;
        end else if (i < `MCS_NUM_CELLS) begin : g_cn
            assign op_a[i]    = {s_q.raw[i][15], s_q.raw[i]};
            assign op_off[i]  = `MCS_ZERO_OFF;
            assign op_gain[i] = $signed({2'b00, s_q.cfg[`MCS_CFG_CELL_GAIN]})
                + $signed({{10{s_q.cfg[`MCS_CFG_DELTA_BASE + i - 1][`MCS_DELTA_MSB]}},
                           s_q.cfg[`MCS_CFG_DELTA_BASE + i - 1][`MCS_DELTA_MSB:0]});
            assign op_byp[i]  = 1'b0;
        end else if (i == `MCS_CH_STACK) begin : g_st
            assign op_a[i]    = {1'b0, s_q.raw[i]};
            assign op_off[i]  = `MCS_ZERO_OFF;
            assign op_gain[i] = {2'b00, s_q.cfg[`MCS_CFG_STACK_GAIN]};
            assign op_byp[i]  = 1'b0;
        end else if (i == `MCS_CH_FAST) begin : g_fa
            assign op_a[i]    = {s_q.raw[i][15], s_q.raw[i]};
            assign op_off[i]  = s_q.cfg[`MCS_CFG_FAST_OFF];
            assign op_gain[i] = {2'b00, s_q.cfg[`MCS_CFG_FAST_GAIN]};
            assign op_byp[i]  = 1'b0;
        end else if (i == `MCS_CH_CURR) begin : g_cu
            assign op_a[i]    = {s_q.raw[i][15], s_q.raw[i]};
            assign op_off[i]  = s_q.cfg[`MCS_CFG_CURR_OFF];
            assign op_gain[i] = {2'b00, s_q.cfg[`MCS_CFG_CURR_GAIN]};
            assign op_byp[i]  = 1'b0;
        end else if (i == `MCS_CH_THERM) begin : g_th
            assign op_a[i]    = {s_q.raw[i][15], s_q.raw[i]};
            assign op_off[i]  = s_q.cfg[`MCS_CFG_THERM_OFF];
            assign op_gain[i] = '0;
            assign op_byp[i]  = 1'b1;
        end else begin : g_di
            assign op_a[i]    = {s_q.raw[i][15], s_q.raw[i]};
            assign op_off[i]  = s_q.cfg[`MCS_CFG_DIE_OFF];
            assign op_gain[i] = {2'b00, s_q.cfg[`MCS_CFG_DIE_GAIN]};
            assign op_byp[i]  = 1'b0;
        end
    end

    assign ai.req_valid = (s_q.st == mcs_pkg::MCS_ST_ISSUE);
    assign ai.req_tag   = s_q.tag;
    assign ai.req_a     = op_a[s_q.tag];
    assign ai.req_off   = op_off[s_q.tag];
    assign ai.req_gain  = op_gain[s_q.tag];
    assign ai.req_byp   = op_byp[s_q.tag];

    mcs_arith u_arith (
        .sys_clk (sys_clk),
        .rst     (rst),
        .ai      (ai.unit)
    );

    assign word = wb_adr[7:2];

    // ==========================================================
    // Next state
    always_comb begin
        s_d         = s_q;
        s_d.ack     = 1'b0;
        s_d.res_vld = '0;

        // Sequencer: one channel in flight, lowest index first
        case (s_q.st)
            mcs_pkg::MCS_ST_IDLE: begin
                if (s_q.pend != '0) begin
                    for (int i = `MCS_NUM_CH - 1; i >= 0; i--) begin
                        if (s_q.pend[i]) begin
                            s_d.tag = `MCS_TAG_W'(i);
                        end
                    end
                    s_d.st = mcs_pkg::MCS_ST_ISSUE;
                end
            end
            mcs_pkg::MCS_ST_ISSUE: begin
                s_d.pend[s_q.tag] = 1'b0;
                s_d.st            = mcs_pkg::MCS_ST_WAIT;
            end
            mcs_pkg::MCS_ST_WAIT: begin
                if (ai.rsp_valid) begin
                    s_d.res[ai.rsp_tag]     = ai.rsp_value;
                    s_d.res_vld[ai.rsp_tag] = 1'b1;
                    s_d.st                  = mcs_pkg::MCS_ST_IDLE;
                end
            end
            default: begin
                s_d.st = mcs_pkg::MCS_ST_IDLE;
            end
        endcase

        // New samples after the clear: a set in the issue cycle survives
        for (int i = 0; i < `MCS_NUM_CH; i++) begin
            if (raw_valid[i]) begin
                s_d.raw[i]  = raw_in[i];
                s_d.pend[i] = 1'b1;
            end
        end

        // Wishbone slave, ack one cycle after the strobe
        if (wb_cyc && wb_stb && !s_q.ack) begin
            s_d.ack = 1'b1;
            s_d.dat = '0;
            if (wb_we) begin
                if (word < `MCS_NUM_CFG) begin
                    if (wb_sel[0]) begin
                        s_d.cfg[word][7:0] = wb_dat_w[7:0];
                    end
                    if (wb_sel[1]) begin
                        s_d.cfg[word][15:8] = wb_dat_w[15:8];
                    end
                    if (word >= `MCS_CFG_DELTA_BASE && word < `MCS_CFG_STACK_GAIN) begin
                        s_d.cfg[word][15:8] = 8'h00;
                    end
                end
            end else if (word < `MCS_NUM_CFG) begin
                s_d.dat = {16'h0000, s_q.cfg[word]};
            end else if (word >= `MCS_WORD_RES_BASE && word < `MCS_WORD_RES_BASE + `MCS_NUM_CH) begin
                s_d.dat = {16'h0000, s_q.res[word - `MCS_WORD_RES_BASE]};
            end else if (word == `MCS_WORD_STATUS) begin
                s_d.dat = {21'h00000, s_q.pend, s_q.st != mcs_pkg::MCS_ST_IDLE};
            end
        end
    end

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end

    assign wb_dat_r  = s_q.dat;
    assign wb_ack    = s_q.ack;
    assign rep_value = s_q.res;
    assign rep_valid = s_q.res_vld;

    // ==========================================================
    // Checks
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (rst);

    a_ack_single: assert property (wb_ack |=> !wb_ack)
        else $error("ack held longer than one cycle");
    a_ack_answer: assert property (wb_cyc && wb_stb && !wb_ack |=> wb_ack)
        else $error("request not acknowledged next cycle");
    a_cell1_gain: assert property (ai.req_valid && ai.req_tag == `MCS_CH_CELL1
        |-> ai.req_gain == $signed({2'b00, s_q.cfg[`MCS_CFG_CELL_GAIN]}) && ai.req_off == 0 && !ai.req_byp)
        else $error("cell one gain not applied");
    a_cell_delta: assert property (ai.req_valid && ai.req_tag > `MCS_CH_CELL1 && ai.req_tag < `MCS_NUM_CELLS
        |-> ai.req_gain == $signed({2'b00, s_q.cfg[`MCS_CFG_CELL_GAIN]})
            + $signed(s_q.cfg[ai.req_tag][`MCS_DELTA_MSB:0]))
        else $error("cell delta gain wrong");
    a_stack_half: assert property (raw_valid[`MCS_CH_STACK]
        |=> s_q.raw[`MCS_CH_STACK] == $past(raw_stack[`MCS_STACK_HI_MSB:`MCS_STACK_HI_LSB]))
        else $error("stack upper half not taken");
    a_curr_path: assert property (ai.req_valid && ai.req_tag == `MCS_CH_CURR
        |-> ai.req_off == $signed(s_q.cfg[`MCS_CFG_CURR_OFF]) && !ai.req_byp
            && ai.req_gain == $signed({2'b00, s_q.cfg[`MCS_CFG_CURR_GAIN]}))
        else $error("second filter calibration wrong");
    a_fast_path: assert property (ai.req_valid && ai.req_tag == `MCS_CH_FAST
        |-> ai.req_off == $signed(s_q.cfg[`MCS_CFG_FAST_OFF]) && !ai.req_byp
            && ai.req_gain == $signed({2'b00, s_q.cfg[`MCS_CFG_FAST_GAIN]}))
        else $error("first filter calibration wrong");
    a_therm_path: assert property (ai.req_valid && ai.req_tag == `MCS_CH_THERM
        |-> ai.req_byp && ai.req_off == $signed(s_q.cfg[`MCS_CFG_THERM_OFF]))
        else $error("thermistor offset path wrong");
    a_die_path: assert property (ai.req_valid && ai.req_tag == `MCS_CH_DIE
        |-> ai.req_off == $signed(s_q.cfg[`MCS_CFG_DIE_OFF]) && !ai.req_byp
            && ai.req_gain == $signed({2'b00, s_q.cfg[`MCS_CFG_DIE_GAIN]}))
        else $error("die temperature calibration wrong");
    a_result_lands: assert property (ai.rsp_valid |=> rep_valid[$past(ai.rsp_tag)]
        && rep_value[$past(ai.rsp_tag)] == $past(ai.rsp_value))
        else $error("result not reported");
    a_sample_served: assert property (raw_valid != '0 |-> ##[1:40] rep_valid != '0)
        else $error("sample never reported");

    c_stack_result: cover property (rep_valid[`MCS_CH_STACK]);
    c_reg_write: cover property (wb_cyc && wb_stb && wb_we && wb_ack);
    c_set_on_clear: cover property (ai.req_valid && raw_valid[ai.req_tag]);

endmodule

// file: verification/mcs_raw_src.sv
// Raw conversion result source feeding the calibration scaler
`timescale 1ns/1ps
`include "mcs_params.svh"

module mcs_raw_src (
    input  wire logic                            sys_clk,            // System clock
    output logic      [`MCS_NUM_CELLS-1:0][15:0] raw_cell,           // Cell results
    output logic      [31:0]                     raw_stack,          // Stack result
    output logic      [15:0]                     raw_coulomb_first,  // First filter result
    output logic      [15:0]                     raw_coulomb_second, // Second filter result
    output logic      [15:0]                     raw_thermistor,     // Thermistor result
    output logic      [15:0]                     raw_die_temp,       // Die temperature result
    output logic      [`MCS_NUM_CH-1:0]          raw_valid           // Result strobes
);
    initial begin
        raw_cell = '0;
        raw_stack = '0;
        raw_coulomb_first = '0;
        raw_coulomb_second = '0;
        raw_thermistor = '0;
        raw_die_temp = '0;
        raw_valid = '0;
    end

    // ==========================================================
    // One strobe cycle, then data lines no longer hold the sample
    task automatic fire(input logic [9:0] mask, input logic [9:0][15:0] v);
        @(posedge sys_clk);
        raw_cell <= v[4:0];
        raw_stack <= {v[5], 16'hBEEF};
        raw_coulomb_first <= v[6];
        raw_coulomb_second <= v[7];
        raw_thermistor <= v[8];
        raw_die_temp <= v[9];
        raw_valid <= mask;
        @(posedge sys_clk);
        raw_valid <= '0;
        raw_cell <= ~v[4:0];
        raw_stack <= ~{v[5], 16'hBEEF};
        raw_coulomb_first <= ~v[6];
        raw_coulomb_second <= ~v[7];
        raw_thermistor <= ~v[8];
        raw_die_temp <= ~v[9];
    endtask
endmodule

// file: verification/tb_mcs_top.sv
// Self-checking bench for the calibration scaler
`timescale 1ns/1ps
`include "mcs_params.svh"

module tb_mcs_top;
    logic                            sys_clk = 1'b0;
    logic                            rst = 1'b1;
    logic                            wb_cyc = 1'b0;
    logic                            wb_stb = 1'b0;
    logic                            wb_we = 1'b0;
    logic [7:0]                      wb_adr = 8'h00;
    logic [3:0]                      wb_sel = 4'h0;
    logic [31:0]                     wb_dat_w = 32'h0;
    logic [31:0]                     wb_dat_r;
    logic                            wb_ack;
    logic [4:0][15:0]                raw_cell;
    logic [31:0]                     raw_stack;
    logic [15:0]                     raw_cf, raw_cs, raw_th, raw_dt;
    logic [9:0]                      raw_valid;
    logic [9:0][15:0]                rep_value;
    logic [9:0]                      rep_valid;
    logic [9:0][15:0]                rv;
    logic [15:0]                     cfg [13];
    logic [31:0]                     rd;
    int                              bad_count = 0;
    int                              check_count = 0;

    always #2 sys_clk = ~sys_clk;

    mcs_raw_src src (.sys_clk(sys_clk), .raw_cell(raw_cell), .raw_stack(raw_stack), .raw_coulomb_first(raw_cf),
        .raw_coulomb_second(raw_cs), .raw_thermistor(raw_th), .raw_die_temp(raw_dt), .raw_valid(raw_valid));

    mcs_top uut (.sys_clk(sys_clk), .rst(rst), .wb_cyc(wb_cyc), .wb_stb(wb_stb), .wb_we(wb_we), .wb_adr(wb_adr),
        .wb_sel(wb_sel), .wb_dat_w(wb_dat_w), .wb_dat_r(wb_dat_r), .wb_ack(wb_ack), .raw_cell(raw_cell),
        .raw_stack(raw_stack), .raw_coulomb_first(raw_cf), .raw_coulomb_second(raw_cs), .raw_thermistor(raw_th),
        .raw_die_temp(raw_dt), .raw_valid(raw_valid), .rep_value(rep_value), .rep_valid(rep_valid));

    // ==========================================================
    // Reference arithmetic and checks
    function automatic logic [15:0] calc(longint a, longint off, longint g, bit byp);
        longint v;
        v = byp ? a - off : ((a - off) * g) >>> 16;
        if (v > 32767) v = 32767;
        if (v < -32768) v = -32768;
        return v[15:0];
    endfunction

    function automatic logic [15:0] exp_ch(int ch, logic [15:0] r);
        longint a;
        a = longint'($signed(r));
        case (ch)
            0: return calc(a, 0, longint'(cfg[0]), 0);
            1, 2, 3, 4: return calc(a, 0, longint'(cfg[0]) + longint'($signed(cfg[ch][7:0])), 0);
            5: return calc(longint'(r), 0, longint'(cfg[5]), 0);
            6: return calc(a, longint'($signed(cfg[9])), longint'(cfg[8]), 0);
            7: return calc(a, longint'($signed(cfg[7])), longint'(cfg[6]), 0);
            8: return calc(a, longint'($signed(cfg[10])), 0, 1);
            default: return calc(a, longint'($signed(cfg[12])), longint'(cfg[11]), 0);
        endcase
    endfunction

    task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
        check_count++;
        if (got !== exp) begin
            bad_count++;
            $display("MISMATCH t=%0t %s got %h exp %h", $time, what, got, exp);
        end
    endtask

    task automatic wb_xfer(input logic we, input logic [7:0] a, input logic [3:0] sel, input logic [31:0] wd);
        int n;
        n = 0;
        @(posedge sys_clk);
        wb_cyc <= 1'b1;
        wb_stb <= 1'b1;
        wb_we <= we;
        wb_adr <= a;
        wb_sel <= sel;
        wb_dat_w <= wd;
        do begin
            @(posedge sys_clk);
            n++;
        end while (wb_ack !== 1'b1);
        chk({31'h0, wb_ack}, 32'h1, "bus acknowledge");
        chk(32'(n), 32'd2, "ack latency");
        rd = wb_dat_r;
        wb_cyc <= 1'b0;
        wb_stb <= 1'b0;
        wb_we <= 1'b0;
    endtask

    task automatic rdc(input logic [7:0] a, input logic [15:0] e);
        wb_xfer(1'b0, a, 4'hF, 32'h0);
        chk(rd, {16'h0, e}, "register read");
    endtask

    task automatic collect(input logic [9:0] mask);
        logic [9:0] seen;
        seen = '0;
        repeat (40) begin
            @(posedge sys_clk);
            for (int c = 0; c < 10; c++) begin
                if (rep_valid[c] === 1'b1) begin
                    seen[c] = 1'b1;
                    chk(rep_value[c], exp_ch(c, rv[c]), "result");
                end
            end
        end
        chk(seen, mask, "updated channels");
    endtask

    task automatic close_out;
        $display("Counts: %0d comparisons, %0d mismatches", check_count, bad_count);
        if (bad_count == 0 && check_count > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask

    // ==========================================================
    // Test sequence
    initial begin
        cfg = '{16'h8000, 16'h0080, 16'h007F, 16'h0001, 16'h00FF, 16'hFFFF, 16'hFFFF, 16'h8000,
                16'h4000, 16'h0100, 16'h7FFF, 16'h2000, 16'hFFF0};
        repeat (5) @(posedge sys_clk);
        rst <= 1'b0;
        for (int i = 0; i < 13; i++) rdc(8'(4 * i), 16'h0000);
        rdc(8'h38, 16'h0000);
        $display("test reset_values done");
        for (int i = 0; i < 13; i++) begin
            wb_xfer(1'b1, 8'(4 * i), 4'hF, {16'hA5A5, cfg[i] | ((i >= 1 && i <= 4) ? 16'hAB00 : 16'h0)});
        end
        wb_xfer(1'b1, 8'h14, 4'h2, 32'h0000_1200);
        cfg[5] = 16'h12FF;
        for (int i = 0; i < 13; i++) rdc(8'(4 * i), cfg[i]);
        $display("test config_access done");
        rv = {16'h0123, 16'h8000, 16'h7FFF, 16'h8000, 16'hFFFF, 16'h4000, 16'hFFFF, 16'h1234, 16'h8000, 16'h7FFF};
        src.fire(10'h3FF, rv);
        collect(10'h3FF);
        rdc(8'h68, 16'h0000);
        for (int c = 0; c < 10; c++) rdc(8'(8'h40 + 4 * c), exp_ch(c, rv[c]));
        $display("test all_channels done");
        wb_xfer(1'b1, 8'h1C, 4'hF, 32'h0000_FFF0);
        cfg[7] = 16'hFFF0;
        rv = ~rv;
        src.fire(10'h281, rv);
        collect(10'h281);
        $display("test selected_channels done");
        close_out();
    end

    initial begin
        #20000;
        bad_count++;
        $display("MISMATCH t=%0t watchdog expired", $time);
        close_out();
    end
endmodule
